// file: rtl/rsu_defs.vh
`ifndef RSU_DEFS_VH
`define RSU_DEFS_VH
// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define RSU_CTRL_OFS      12'h000
`define RSU_STATUS_OFS    12'h004
`define RSU_START_OFS     12'h008
`define RSU_USERPIN_OFS   12'h00c
// ----------------------------------------
// control register fields
// ----------------------------------------
`define RSU_CTRL_SCHEME_LSB 0
`define RSU_CTRL_AUTO_BIT   2
`define RSU_CTRL_DECOMP_BIT 3
`define RSU_CTRL_SECURE_BIT 4
`define RSU_CTRL_CLK4_BIT   5
`define RSU_CTRL_RECFG_BIT  8
`define RSU_CTRL_RESET      6'h00
// ----------------------------------------
// configuration schemes
// ----------------------------------------
`define RSU_SCH_AS        2'h0
`define RSU_SCH_FPP       2'h1
`define RSU_SCH_PS        2'h2
`define RSU_SCH_PPA       2'h3
`define RSU_CONFIG_SCHEME_SELECT_REMOTE   4'h4
// ----------------------------------------
// parameter selector codes
// ----------------------------------------
`define RSU_P_STATUS      3'h0
`define RSU_P_WD_TIMEOUT  3'h2
`define RSU_P_WD_ENABLE   3'h3
`define RSU_P_PAGE        3'h4
`define RSU_P_CUR_CFG     3'h5
// ----------------------------------------
// reset values and crc polynomial
// ----------------------------------------
`define RSU_PAGE_RESET    7'h00
`define RSU_WDT_RESET     12'h000
`define RSU_CRC_POLY      16'h1021
`define RSU_CRC_INIT      16'hffff
`endif

// file: rtl/pin_sync.v
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             rst_q_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  // ----------------------------------------
  // two flops per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stab_q;
      always @(posedge ref_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else if (ce) begin
          meta_q <= async_in[i];
          stab_q <= meta_q;
        end
      end
      assign sync_out[i] = stab_q;
    end
  endgenerate
endmodule // pin_sync

// file: rtl/frame_crc_check.v
`include "rsu_defs.vh"
module frame_crc_check (
  input  wire       ref_clk,
  input  wire       rst_q_n,
  input  wire       ce,
  input  wire       clear,
  input  wire [7:0] data,
  input  wire       data_valid,
  input  wire       frame_last,
  output reg        crc_error_q,
  output reg        frame_open_q
);
  reg  [15:0] crc_q;
  reg  [15:0] crc_d;
  integer     b;
  // ----------------------------------------
  // byte-wide crc, trailer included
  // ----------------------------------------
  always @* begin
    crc_d = crc_q;
    for (b = 7; b >= 0; b = b - 1) begin
      if (crc_d[15] ^ data[b]) begin
        crc_d = {crc_d[14:0], 1'b0} ^ `RSU_CRC_POLY;
      end else begin
        crc_d = {crc_d[14:0], 1'b0};
      end
    end
  end
  // a clean frame with its crc appended leaves zero
  always @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      crc_q        <= `RSU_CRC_INIT;
      crc_error_q  <= 1'b0;
      frame_open_q <= 1'b0;
    end else if (ce) begin
      crc_error_q <= 1'b0;
      if (clear) begin
        crc_q        <= `RSU_CRC_INIT;
        frame_open_q <= 1'b0;
      end else if (data_valid) begin
        if (frame_last) begin
          crc_q        <= `RSU_CRC_INIT;
          frame_open_q <= 1'b0;
          crc_error_q  <= (crc_d != 16'h0000);
        end else begin
          crc_q        <= crc_d;
          frame_open_q <= 1'b1;
        end
      end
    end
  end
endmodule // frame_crc_check

// file: rtl/remote_upgrade_page_select.v
// The implementer's own choices: the address map and register access over APB.
`include "rsu_defs.vh"
// Operation
// - selector 101 reads indicator, writes refused
// - indicator 0 factory, 1 application, resets 0
// - serial scheme passes 7-bit page internally
// - page expands to 24-bit start address
// - factory start address is all zeros
// - bit23 zero, page 22..16, low zero
// - serial scheme frees select pins as user
// - always fall back on error or watchdog; code falls back only in remote mode or with auto bit set
// - check frame crc, flag bad data
// - status pulse loads factory image; code does so only from application target, in remote mode or auto bit
// - decompress/security only parallel-4x or serial; code allows passive serial or parallel with clk4 bit
// - user access to shift, reset, watchdog
module remote_upgrade_page_select #(
  parameter PAGE_BITS = 7
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [2:0]  param_sel,
  input  wire        param_read,
  input  wire        param_write,
  input  wire [11:0] param_data_in,
  output reg  [11:0] param_data_out,
  output reg         param_busy,
  input  wire [3:0]  config_scheme_select,
  input  wire        remote_local_select,
  input  wire        config_status_n,
  input  wire        config_complete,
  input  wire [7:0]  config_data,
  input  wire        config_data_valid,
  input  wire        config_frame_last,
  input  wire        watchdog_timeout,
  input  wire        core_error,
  input  wire        user_shift_en,
  input  wire        user_shift_in,
  output wire        user_shift_out,
  output reg         logic_array_reset,
  output reg         watchdog_clear,
  input  wire        user_watchdog_reset,
  output reg         config_load_start,
  output reg  [23:0] config_start_address,
  output reg  [6:0]  page_start_internal,
  output reg         config_is_application,
  output reg  [2:0]  page_select_pins,
  output reg  [2:0]  page_select_pins_oe,
  output reg         feature_decomp_en,
  output reg         feature_secure_en
);
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  reg        rst_m_q;
  reg        rst_q_n;
  wire [6:0] pins_s;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_q_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q_n <= rst_m_q;
    end
  end
  pin_sync #(
    .WIDTH    (7)
  ) i_pin_sync (
    .ref_clk  (ref_clk),
    .rst_q_n  (rst_q_n),
    .ce       (ce),
    .async_in ({config_scheme_select, remote_local_select,
                config_status_n, config_complete}),
    .sync_out (pins_s)
  );
  wire [3:0] config_scheme_select_s      = pins_s[6:3];
  wire       rlsel_s     = pins_s[2];
  wire       status_n_s  = pins_s[1];
  wire       complete_s  = pins_s[0];
  reg        status_n_q;
  reg        complete_q;
  wire       status_fall = status_n_q & ~status_n_s;
  wire       complete_rise = complete_s & ~complete_q;
  wire       remote_en   = (config_scheme_select_s == `RSU_CONFIG_SCHEME_SELECT_REMOTE);
  // ----------------------------------------
  // stored state
  // ----------------------------------------
  localparam ST_LOAD = 2'd0;
  localparam ST_RUN  = 2'd1;
  localparam ST_IDLE = 2'd2;
  reg [1:0]  state_q;
  reg [5:0]  ctrl_q;
  reg [6:0]  page_q;
  reg [11:0] wd_timeout_q;
  reg        wd_enable_q;
  reg [4:0]  reason_q;
  reg [5:0]  user_pin_q;
  reg [12:0] shift_q;
  reg        load_req_q;
  reg        app_target_q;
  wire [1:0] scheme     = ctrl_q[`RSU_CTRL_SCHEME_LSB +: 2];
  wire       auto_recfg = ctrl_q[`RSU_CTRL_AUTO_BIT];
  wire       as_mode    = (scheme == `RSU_SCH_AS);
  // ----------------------------------------
  // frame crc checking
  // ----------------------------------------
  wire crc_error;
  wire frame_open;
  frame_crc_check i_frame_crc_check (
    .ref_clk      (ref_clk),
    .rst_q_n      (rst_q_n),
    .ce           (ce),
    .clear        (config_load_start),
    .data         (config_data),
    .data_valid   (config_data_valid & (state_q == ST_LOAD)),
    .frame_last   (config_frame_last),
    .crc_error_q  (crc_error),
    .frame_open_q (frame_open)
  );
  // incomplete data: done seen mid-frame
  wire cfg_err   = crc_error | (complete_rise & frame_open);
  wire run_err   = watchdog_timeout & wd_enable_q;
  // recovery is forced on whenever remote update is on
  wire fall_ok   = remote_en | auto_recfg;
  wire fallback  = fall_ok & app_target_q &
                   (((state_q == ST_LOAD) & cfg_err) |
                    ((state_q == ST_RUN) & (run_err | core_error)) |
                    status_fall);
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc      = psel & penable;
  wire wr_ctrl  = acc & pwrite & (paddr == `RSU_CTRL_OFS);
  wire wr_upin  = acc & pwrite & (paddr == `RSU_USERPIN_OFS);
  wire mapped   = (paddr == `RSU_CTRL_OFS) |
                  (paddr == `RSU_STATUS_OFS) |
                  (paddr == `RSU_START_OFS) |
                  (paddr == `RSU_USERPIN_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  wire recfg_req = wr_ctrl & pwdata[`RSU_CTRL_RECFG_BIT];
  // ----------------------------------------
  // parameter port decode
  // ----------------------------------------
  wire legal_sel = (param_sel == `RSU_P_STATUS) |
                   (param_sel == `RSU_P_WD_TIMEOUT) |
                   (param_sel == `RSU_P_WD_ENABLE) |
                   (param_sel == `RSU_P_PAGE) |
                   (param_sel == `RSU_P_CUR_CFG);
  // writes only land while the factory image runs
  wire pwr_ok = param_write & legal_sel & ~app_target_q &
                (state_q == ST_RUN);
  reg [11:0] param_rd;
  always @* begin
    case (param_sel)
      `RSU_P_STATUS:     param_rd = {7'h00, reason_q};
      `RSU_P_WD_TIMEOUT: param_rd = wd_timeout_q;
      `RSU_P_WD_ENABLE:  param_rd = {11'h000, wd_enable_q};
      `RSU_P_PAGE:       param_rd = {5'h00, page_q};
      `RSU_P_CUR_CFG:    param_rd = {11'h000, app_target_q};
      default:           param_rd = 12'h000;
    endcase
  end
  // ----------------------------------------
  // sequencing and registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state_q           <= ST_LOAD;
      ctrl_q            <= `RSU_CTRL_RESET;
      page_q            <= `RSU_PAGE_RESET;
      wd_timeout_q      <= `RSU_WDT_RESET;
      wd_enable_q       <= 1'b0;
      reason_q          <= 5'h00;
      user_pin_q        <= 6'h00;
      app_target_q      <= 1'b0;
      load_req_q        <= 1'b1;
      config_load_start <= 1'b0;
      logic_array_reset <= 1'b1;
      watchdog_clear    <= 1'b0;
      status_n_q        <= 1'b0; // synchroniser resets low, no false fall
      complete_q        <= 1'b0;
      param_busy        <= 1'b0;
      param_data_out    <= 12'h000;
    end else if (ce) begin
      status_n_q        <= status_n_s;
      complete_q        <= complete_s;
      config_load_start <= load_req_q;
      load_req_q        <= 1'b0;
      watchdog_clear    <= user_watchdog_reset;
      param_busy        <= (param_read | param_write) & legal_sel;
      if (param_read & legal_sel) begin
        param_data_out <= param_rd;
      end
      if (pwr_ok) begin
        case (param_sel)
          `RSU_P_WD_TIMEOUT: wd_timeout_q <= param_data_in;
          `RSU_P_WD_ENABLE:  wd_enable_q  <= param_data_in[0];
          `RSU_P_PAGE:       page_q       <= param_data_in[6:0];
          default:           page_q       <= page_q;
        endcase
      end
      if (wr_ctrl) begin
        ctrl_q <= pwdata[5:0];
      end
      if (wr_upin) begin
        user_pin_q <= pwdata[5:0];
      end
      case (state_q)
        ST_LOAD: begin
          logic_array_reset <= 1'b1;
          if (fallback) begin
            app_target_q <= 1'b0;
            load_req_q   <= 1'b1;
            reason_q     <= {3'b000, status_fall, cfg_err};
          end else if (complete_rise & ~cfg_err) begin
            state_q <= ST_RUN;
          end else if (cfg_err) begin
            state_q <= ST_IDLE;
          end
        end
        ST_RUN: begin
          logic_array_reset <= 1'b0;
          if (fallback) begin
            state_q      <= ST_LOAD;
            app_target_q <= 1'b0;
            load_req_q   <= 1'b1;
            reason_q     <= {run_err, 1'b0, core_error,
                             status_fall, 1'b0};
          end else if (recfg_req & ~app_target_q) begin
            state_q      <= ST_LOAD;
            app_target_q <= remote_en | ~rlsel_s;
            load_req_q   <= 1'b1;
            reason_q     <= 5'h08;
          end
        end
        ST_IDLE: begin
          logic_array_reset <= 1'b1;
          if (recfg_req) begin
            state_q    <= ST_LOAD;
            load_req_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end
  // ----------------------------------------
  // user shift register
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      shift_q <= 13'h0000;
    end else if (ce) begin
      if (user_shift_en) begin
        shift_q <= {user_shift_in, shift_q[12:1]};
      end else begin
        shift_q <= {app_target_q, page_q, reason_q};
      end
    end
  end
  assign user_shift_out = shift_q[0];
  // ----------------------------------------
  // start address and page pins
  // ----------------------------------------
  wire [6:0] page_used = page_q & ((7'h01 << PAGE_BITS) - 7'h01);
  always @(posedge ref_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      config_start_address  <= 24'h00_0000;
      page_start_internal   <= 7'h00;
      config_is_application <= 1'b0;
      page_select_pins      <= 3'h0;
      page_select_pins_oe   <= 3'h0;
      feature_decomp_en     <= 1'b0;
      feature_secure_en     <= 1'b0;
    end else if (ce) begin
      config_is_application <= app_target_q;
      if (as_mode & app_target_q) begin
        page_start_internal  <= page_used;
        config_start_address <= {1'b0, page_used,
                                 16'h0000};
      end else begin
        page_start_internal  <= 7'h00;
        config_start_address <= 24'h00_0000;
      end
      if (as_mode) begin
        page_select_pins    <= user_pin_q[2:0];
        page_select_pins_oe <= user_pin_q[5:3];
      end else begin
        page_select_pins    <= app_target_q ? page_q[2:0] : 3'h0;
        page_select_pins_oe <= 3'h7;
      end
      feature_decomp_en <= ctrl_q[`RSU_CTRL_DECOMP_BIT] &
                           ((scheme == `RSU_SCH_PS) |
                            ((scheme == `RSU_SCH_FPP) &
                             ctrl_q[`RSU_CTRL_CLK4_BIT]));
      feature_secure_en <= ctrl_q[`RSU_CTRL_SECURE_BIT] &
                           ((scheme == `RSU_SCH_PS) |
                            ((scheme == `RSU_SCH_FPP) &
                             ctrl_q[`RSU_CTRL_CLK4_BIT]));
    end
  end
  // ----------------------------------------
  // apb read data
  // ----------------------------------------
  always @* begin
    case (paddr)
      `RSU_CTRL_OFS:    prdata = {26'h000_0000, ctrl_q};
      `RSU_STATUS_OFS:  prdata = {16'h0000, feature_secure_en,
                                  feature_decomp_en, rlsel_s,
                                  remote_en, state_q, reason_q,
                                  wd_enable_q, page_q[2:0],
                                  config_is_application};
      `RSU_START_OFS:   prdata = {8'h00, config_start_address};
      `RSU_USERPIN_OFS: prdata = {26'h000_0000, user_pin_q};
      default:          prdata = 32'h0000_0000;
    endcase
  end
endmodule // remote_upgrade_page_select

// file: test/rsu_monitor.sv
// ----------------------------------------
// port checker
// ----------------------------------------
module rsu_monitor (
  input logic        ref_clk,
  input logic        rst_n,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic [2:0]  param_sel,
  input logic        param_read,
  input logic        param_write,
  input logic [11:0] param_data_out,
  input logic        param_busy,
  input logic [3:0]  config_scheme_select,
  input logic        config_status_n,
  input logic        user_watchdog_reset,
  input logic        watchdog_clear,
  input logic        config_load_start,
  input logic        logic_array_reset,
  input logic [23:0] config_start_address,
  input logic [6:0]  page_start_internal,
  input logic        config_is_application
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_app_read: assert property (
    ce && param_read && param_sel == 3'h5 |=> param_busy &&
    param_data_out == {11'h000, $past(config_is_application)})
    else $error("indicator read wrong");
  chk_illegal_sel: assert property (
    ce && (param_read || param_write) && param_sel inside {3'h1, 3'h6, 3'h7}
    |=> !param_busy && $stable(param_data_out))
    else $error("illegal selector acted");
  chk_factory_addr: assert property (
    !logic_array_reset && !config_is_application
    |-> config_start_address == 24'h00_0000)
    else $error("factory start address not zero");
  chk_app_addr: assert property (
    !logic_array_reset && config_is_application
    |-> config_start_address == {1'b0, page_start_internal, 16'h0000})
    else $error("application start address malformed");
  chk_load_pulse: assert property (
    config_load_start |=> !config_load_start && logic_array_reset)
    else $error("load start not a single pulse");
  chk_status_fallback: assert property (
    $fell(config_status_n) && config_scheme_select == 4'h4 &&
    config_is_application && !logic_array_reset |-> ##[1:8] config_load_start)
    else $error("no reload after status pulse");
  chk_apb_ready: assert property (
    psel |-> pready)
    else $error("wait state inserted");
  chk_unmapped: assert property (
    psel && penable && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c})
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_wd_clear: assert property (
    ce |=> watchdog_clear == $past(user_watchdog_reset))
    else $error("watchdog clear not forwarded");
endmodule // rsu_monitor

// file: test/cfg_memory_model.sv
// ----------------------------------------
// configuration memory on the far side
// ----------------------------------------
module cfg_memory_model (
  input  logic       ref_clk,
  input  logic       config_load_start,
  input  logic       corrupt,
  input  logic       slow,
  input  logic       status_pulse,
  output logic [7:0] config_data,
  output logic       config_data_valid,
  output logic       config_frame_last,
  output logic       config_complete,
  output logic       config_status_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] crc;
  logic [7:0]  p;
  logic        bad;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++)
      r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    return r;
  endfunction

  task automatic put(input logic [7:0] b, input logic last);
    config_data       <= b;
    config_data_valid <= 1'b1;
    config_frame_last <= last;
    @(posedge ref_clk);
    if (slow) begin
      config_data_valid <= 1'b0;
      config_data       <= ~b;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // frame of four bytes plus crc per load request, image store read only
  initial begin
    config_data       = 8'h00;
    config_data_valid = 1'b0;
    config_frame_last = 1'b0;
    config_complete   = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (config_load_start) begin
        bad = corrupt;
        config_complete <= 1'b0;
        crc = 16'hffff;
        for (int i = 0; i < 4; i++) begin
          p = 8'ha0 + 8'(i);
          crc = crc_byte(crc, p);
          put((bad && i == 0) ? p ^ 8'h01 : p, 1'b0);
        end
        put(crc[15:8], 1'b0);
        put(crc[7:0], 1'b1);
        config_data_valid <= 1'b0;
        config_frame_last <= 1'b0;
        config_data       <= ~crc[7:0];
        if (!bad) begin
          repeat (2) @(posedge ref_clk);
          config_complete <= 1'b1;
        end
      end
    end
  end

  initial begin
    config_status_n = 1'b1;
    forever begin
      @(posedge ref_clk);
      if (status_pulse) begin
        config_status_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        config_status_n <= 1'b1;
      end
    end
  end
endmodule // cfg_memory_model

// file: test/remote_upgrade_page_select_bench.sv
`include "rsu_defs.vh"
module remote_upgrade_page_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, param_data_in, param_data_out;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  param_sel, page_select_pins, page_select_pins_oe;
  logic        param_read, param_write, param_busy, busy, rerr;
  logic [11:0] pout;
  logic [3:0]  config_scheme_select;
  logic        remote_local_select, config_status_n, config_complete;
  logic [7:0]  config_data;
  logic        config_data_valid, config_frame_last, watchdog_timeout;
  logic        core_error, user_shift_en, user_shift_in, user_shift_out;
  logic        logic_array_reset, watchdog_clear, user_watchdog_reset;
  logic        config_load_start, feature_decomp_en, feature_secure_en;
  logic [23:0] config_start_address;
  logic [6:0]  page_start_internal;
  logic        config_is_application, corrupt, slow, status_pulse;
  int          fails, n_tests, cycles;

  remote_upgrade_page_select i_remote_upgrade_page_select (.*);
  cfg_memory_model i_cfg_memory_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // bus and parameter drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check("pready", 1, n < 50);
  endtask

  task automatic par(input logic wr, input logic [2:0] s,
                     input logic [11:0] d);
    @(posedge ref_clk);
    param_sel     <= s;
    param_write   <= wr;
    param_read    <= !wr;
    param_data_in <= d;
    @(posedge ref_clk);
    param_read  <= 1'b0;
    param_write <= 1'b0;
    @(posedge ref_clk);
    busy = param_busy;
    pout = param_data_out;
  endtask

  task automatic wait_load;
    int n;
    n = 0;
    while (config_load_start !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    check("load start", 1, n < 100);
  endtask

  task automatic wait_up;
    int n;
    n = 0;
    while (logic_array_reset !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check("run", 1, n < 400);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    wait_load();
    wait_up();
    check("app", 0, config_is_application);
    check("start", 0, config_start_address);
    par(0, 3'h5, 12'h000);
    check("busy", 1, busy);
    check("ind", 0, pout);
    $display("reset test done");
  endtask

  task automatic t_illegal;
    logic [2:0] s[3] = '{3'h1, 3'h6, 3'h7};
    par(1, 3'h4, 12'h05a);
    check("page wr", 1, busy);
    foreach (s[i]) begin
      par(1, s[i], 12'h07f);
      check("ill wr", 0, busy);
      par(0, s[i], 12'h000);
      check("ill rd", 0, busy);
    end
    par(1, 3'h5, 12'h001);
    par(0, 3'h5, 12'h000);
    check("ind ro", 0, pout);
    par(0, 3'h4, 12'h000);
    check("page", 12'h05a, pout);
    $display("selector test done");
  endtask

  task automatic t_app;
    slow <= 1'b1;
    apb(1, `RSU_CTRL_OFS, 32'h0000_0100);
    wait_load();
    wait_up();
    check("app", 1, config_is_application);
    check("start", 24'h5a_0000, config_start_address);
    check("page int", 7'h5a, page_start_internal);
    apb(0, `RSU_STATUS_OFS, 32'h0000_0000);
    check("status app", 1, rdata[0]);
    par(0, 3'h5, 12'h000);
    check("ind", 1, pout);
    par(1, 3'h4, 12'h011);
    check("wr refused", 1, busy);
    par(0, 3'h4, 12'h000);
    check("page kept", 12'h05a, pout);
    slow <= 1'b0;
    $display("application test done");
  endtask

  task automatic t_status;
    @(posedge ref_clk);
    status_pulse <= 1'b1;
    @(posedge ref_clk);
    status_pulse <= 1'b0;
    wait_load();
    wait_up();
    check("app", 0, config_is_application);
    check("start", 0, config_start_address);
    apb(0, `RSU_STATUS_OFS, 32'h0000_0000);
    check("reason pin", 1, rdata[6]);
    $display("status pin test done");
  endtask

  task automatic t_crc;
    corrupt <= 1'b1;
    apb(1, `RSU_CTRL_OFS, 32'h0000_0100);
    wait_load();
    corrupt <= 1'b0;
    wait_up();
    check("app", 0, config_is_application);
    check("start", 0, config_start_address);
    apb(0, `RSU_STATUS_OFS, 32'h0000_0000);
    check("reason crc", 1, rdata[5]);
    $display("crc test done");
  endtask

  task automatic t_pins;
    apb(1, `RSU_USERPIN_OFS, 32'h0000_003d);
    check("shift out", 1, user_shift_out);
    user_shift_en       <= 1'b1;
    user_shift_in       <= 1'b1;
    user_watchdog_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("shifted", 0, user_shift_out);
    user_shift_en       <= 1'b0;
    user_watchdog_reset <= 1'b0;
    check("pins", 3'h5, page_select_pins);
    check("pins oe", 3'h7, page_select_pins_oe);
    apb(0, 12'h010, 32'h0000_0000);
    check("unmapped err", 1, rerr);
    check("unmapped data", 0, rdata);
    apb(0, `RSU_START_OFS, 32'h0000_0000);
    check("start reg", 0, rdata);
    $display("pin test done");
  endtask

  task automatic t_feat;
    logic [31:0] c[4] = '{32'h0000_0039, 32'h0000_0019,
                          32'h0000_001a, 32'h0000_001b};
    logic        e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    foreach (c[i]) begin
      apb(1, `RSU_CTRL_OFS, c[i]);
      repeat (2) @(posedge ref_clk);
      check("decomp", e[i], feature_decomp_en);
      check("secure", e[i], feature_secure_en);
    end
    $display("feature test done");
  endtask

  task automatic t_core;
    apb(1, `RSU_CTRL_OFS, 32'h0000_0100);
    wait_load();
    wait_up();
    core_error <= 1'b1;
    wait_load();
    core_error <= 1'b0;
    wait_up();
    check("core app", 0, config_is_application);
    apb(0, `RSU_STATUS_OFS, 32'h0000_0000);
    check("reason core", 1, rdata[7]);
    $display("core error test done");
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, param_read, param_write} = '0;
    {corrupt, slow, status_pulse, watchdog_timeout, core_error} = '0;
    {user_shift_en, user_shift_in, user_watchdog_reset} = '0;
    {remote_local_select, paddr, pwdata, param_sel, param_data_in} = '0;
    ce = 1'b1;
    config_scheme_select = `RSU_CONFIG_SCHEME_SELECT_REMOTE;
    fails = 0;
    n_tests = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_illegal();
    t_app();
    t_status();
    t_crc();
    t_pins();
    t_feat();
    t_core();
    end_sim();
  end
endmodule // remote_upgrade_page_select_bench

bind remote_upgrade_page_select rsu_monitor i_rsu_monitor (.*);
